// File: mcc_channel_config.v
// channel configuration register with AXI4-Lite access and the steering it applies
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "mcc_map.vh"

module mcc_channel_config (
    input  wire                        aclk,
    input  wire                        aresetn,
    input  wire [`MCC_ADDR_W-1:0]      s_axi_awaddr,
    input  wire                        s_axi_awvalid,
    output wire                        s_axi_awready,
    input  wire [`MCC_DATA_W-1:0]      s_axi_wdata,
    input  wire [3:0]                  s_axi_wstrb,
    input  wire                        s_axi_wvalid,
    output wire                        s_axi_wready,
    output reg  [1:0]                  s_axi_bresp,
    output reg                         s_axi_bvalid,
    input  wire                        s_axi_bready,
    input  wire [`MCC_ADDR_W-1:0]      s_axi_araddr,
    input  wire                        s_axi_arvalid,
    output wire                        s_axi_arready,
    output reg  [`MCC_DATA_W-1:0]      s_axi_rdata,
    output reg  [1:0]                  s_axi_rresp,
    output reg                         s_axi_rvalid,
    input  wire                        s_axi_rready,
    input  wire [`MCC_VBUS_W-1:0]      volt_in,
    input  wire [`MCC_IBUS_W-1:0]      cur_in,
    input  wire [`MCC_IBUS_W-1:0]      cur_integ_in,
    input  wire                        fast_port_clock_in,
    input  wire                        third_pulse_in,
    output reg  [`MCC_VBUS_W-1:0]      volt_res,
    output reg  [`MCC_IBUS_W-1:0]      cur_res,
    output reg  [`MCC_VBUS_W-1:0]      pwr_volt,
    output wire                        integrator_on,
    output wire                        voltage_adc_grounded,
    output wire                        current_adc_grounded,
    output wire                        fast_data_port_on,
    output reg                         shared_pin_out,
    output wire                        soft_reset_out
);

    // phase paired with a current: base phase advanced by the code, reserved code as default
    function [1:0] mcc_pair_phase;
        input [1:0] code;
        input [1:0] base;
        reg   [2:0] sum;
        begin
            if (code == `MCC_SEL_RSVD) begin
                sum = {1'b0, base} + {1'b0, `MCC_SEL_DEFAULT};
            end else begin
                sum = {1'b0, base} + {1'b0, code};
            end
            if (sum >= `MCC_NUM_PHASES) begin
                sum = sum - `MCC_NUM_PHASES;
            end
            mcc_pair_phase = sum[1:0];
        end
    endfunction

    // voltage sample of one phase out of the packed voltage bus
    function [`MCC_SAMPLE_W-1:0] mcc_pick_volt;
        input [1:0]             phase;
        input [`MCC_VBUS_W-1:0] vbus;
        begin
            case (phase)
                `MCC_PHASE_A: begin
                    mcc_pick_volt = vbus[0 +: `MCC_SAMPLE_W];
                end
                `MCC_PHASE_B: begin
                    mcc_pick_volt = vbus[`MCC_SAMPLE_W +: `MCC_SAMPLE_W];
                end
                `MCC_PHASE_C: begin
                    mcc_pick_volt = vbus[2*`MCC_SAMPLE_W +: `MCC_SAMPLE_W];
                end
                default: begin
                    mcc_pick_volt = vbus[0 +: `MCC_SAMPLE_W];
                end
            endcase
        end
    endfunction

    // registers reachable over the bus
    localparam [1:0] ADDR_SEL_CFG  = 2'b00;
    localparam [1:0] ADDR_SEL_STAT = 2'b01;
    localparam [1:0] ADDR_SEL_NONE = 2'b10;

    // register picked by a byte address; the byte-lane bits take no part
    function [1:0] mcc_addr_sel;
        input [`MCC_ADDR_W-1:0] addr;
        reg   [`MCC_ADDR_W-1:0] cfg_ofs;
        reg   [`MCC_ADDR_W-1:0] stat_ofs;
        begin
            cfg_ofs  = `MCC_CFG_OFS;
            stat_ofs = `MCC_STAT_OFS;
            if (addr[`MCC_ADDR_W-1:`MCC_WORD_LSB]
                == cfg_ofs[`MCC_ADDR_W-1:`MCC_WORD_LSB]) begin
                mcc_addr_sel = ADDR_SEL_CFG;
            end else if (addr[`MCC_ADDR_W-1:`MCC_WORD_LSB]
                         == stat_ofs[`MCC_ADDR_W-1:`MCC_WORD_LSB]) begin
                mcc_addr_sel = ADDR_SEL_STAT;
            end else begin
                mcc_addr_sel = ADDR_SEL_NONE;
            end
        end
    endfunction

    reg  [`MCC_CFG_W-1:0]   cfg_reg;
    reg  [`MCC_CFG_W-1:0]   cfg_next;
    reg  [`MCC_CNT_W-1:0]   soft_reset_trigger_cnt_reg;
    reg  [`MCC_CNT_W-1:0]   soft_reset_trigger_cnt_next;
    reg                     aw_held_reg;
    reg  [`MCC_ADDR_W-1:0]  aw_addr_reg;
    reg                     w_held_reg;
    reg  [`MCC_DATA_W-1:0]  w_data_reg;
    reg  [3:0]              w_strb_reg;
    wire                    aw_take;
    wire                    w_take;
    wire                    ar_take;
    wire                    wr_fire;
    wire                    wr_cfg_hit;
    wire                    wr_map_hit;
    wire                    soft_reset_trigger_req;
    wire [1:0]              pair_phase [0:2];
    wire [`MCC_DATA_W-1:0]  stat_word;
    wire [`MCC_DATA_W-1:0]  cfg_word;
    wire [`MCC_VBUS_W-1:0]  volt_eff;
    wire [`MCC_IBUS_W-1:0]  cur_eff;
    wire [1:0]              wr_sel;
    wire [1:0]              rd_sel;
    reg                     soft_reset_trigger_busy_reg;
    wire [`MCC_VBUS_W-1:0]  volt_res_next;
    wire [`MCC_IBUS_W-1:0]  cur_res_next;
    wire [`MCC_VBUS_W-1:0]  pwr_volt_next;

    // bus handshakes: write address and data each held until the write fires, none accepted again until the response is taken
    assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign aw_take       = s_axi_awvalid & s_axi_awready;
    assign w_take        = s_axi_wvalid & s_axi_wready;
    assign ar_take       = s_axi_arvalid & s_axi_arready;
    assign wr_fire       = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign wr_sel        = mcc_addr_sel(aw_addr_reg);
    assign rd_sel        = mcc_addr_sel(s_axi_araddr);
    assign wr_cfg_hit    = (wr_sel == ADDR_SEL_CFG);
    assign wr_map_hit    = (wr_sel != ADDR_SEL_NONE);
    assign soft_reset_trigger_req     = wr_fire & wr_cfg_hit & w_strb_reg[0]
                         & w_data_reg[`MCC_SOFT_RESET_TRIGGER_BIT];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= {`MCC_ADDR_W{1'b0}};
            w_held_reg  <= 1'b0;
            w_data_reg  <= {`MCC_DATA_W{1'b0}};
            w_strb_reg  <= 4'h0;
        end else begin
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_held_reg <= 1'b0;
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_held_reg <= 1'b0;
            end
        end
    end

    // register update: reserved bits and the self-clearing reset bit never stored
    always @* begin
        cfg_next       = cfg_reg;
        soft_reset_trigger_cnt_next = soft_reset_trigger_cnt_reg;
        if (soft_reset_trigger_cnt_reg != {`MCC_CNT_W{1'b0}}) begin
            soft_reset_trigger_cnt_next = soft_reset_trigger_cnt_reg - 1'b1;
        end
        if (soft_reset_trigger_req) begin
            cfg_next       = `MCC_CFG_RESET;
            soft_reset_trigger_cnt_next = `MCC_SOFT_RESET_TRIGGER_CYCLES;
        end else if (wr_fire && wr_cfg_hit) begin
            if (w_strb_reg[0]) begin
                cfg_next[7:0] = w_data_reg[7:0];
            end
            if (w_strb_reg[1]) begin
                cfg_next[15:8] = w_data_reg[15:8];
            end
            cfg_next = cfg_next & `MCC_CFG_MASK;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg_reg       <= `MCC_CFG_RESET;
            soft_reset_trigger_cnt_reg <= {`MCC_CNT_W{1'b0}};
        end else begin
            cfg_reg       <= cfg_next;
            soft_reset_trigger_cnt_reg <= soft_reset_trigger_cnt_next;
        end
    end

    // soft reset level held in a flip-flop so the output carries no decode glitch
    always @(posedge aclk) begin
        if (!aresetn) begin
            soft_reset_trigger_busy_reg <= 1'b0;
        end else begin
            soft_reset_trigger_busy_reg <= (soft_reset_trigger_cnt_next != {`MCC_CNT_W{1'b0}});
        end
    end

    // write response one cycle after both channels are held
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `MCC_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map_hit ? `MCC_RESP_OKAY : `MCC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // readback words
    assign cfg_word  = {{(`MCC_DATA_W-`MCC_CFG_W){1'b0}}, cfg_reg};
    assign stat_word = {{(`MCC_DATA_W-`MCC_STAT_W){1'b0}},
                        pair_phase[2],
                        pair_phase[1],
                        pair_phase[0],
                        1'b0,
                        soft_reset_out};

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= {`MCC_DATA_W{1'b0}};
            s_axi_rresp  <= `MCC_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                case (rd_sel)
                    ADDR_SEL_CFG: begin
                        s_axi_rdata <= cfg_word;
                        s_axi_rresp <= `MCC_RESP_OKAY;
                    end
                    ADDR_SEL_STAT: begin
                        s_axi_rdata <= stat_word;
                        s_axi_rresp <= `MCC_RESP_OKAY;
                    end
                    default: begin
                        s_axi_rdata <= {`MCC_DATA_W{1'b0}};
                        s_axi_rresp <= `MCC_RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // control levels straight from the stored fields; soft reset level from its busy flip-flop
    assign integrator_on        = cfg_reg[`MCC_INTEG_BIT];
    assign voltage_adc_grounded = cfg_reg[`MCC_VGND_BIT];
    assign current_adc_grounded = cfg_reg[`MCC_IGND_BIT];
    assign fast_data_port_on    = cfg_reg[`MCC_FDP_BIT];
    assign soft_reset_out       = soft_reset_trigger_busy_reg;

    // power-path pairing of each phase current
    assign pair_phase[0] = mcc_pair_phase(cfg_reg[`MCC_SELA_LSB +: `MCC_SEL_W],
                                          `MCC_PHASE_A);
    assign pair_phase[1] = mcc_pair_phase(cfg_reg[`MCC_SELB_LSB +: `MCC_SEL_W],
                                          `MCC_PHASE_B);
    assign pair_phase[2] = mcc_pair_phase(cfg_reg[`MCC_SELC_LSB +: `MCC_SEL_W],
                                          `MCC_PHASE_C);

    // converter grounding and integrator choice
    assign volt_eff = voltage_adc_grounded ? {`MCC_VBUS_W{1'b0}} : volt_in;
    assign cur_eff  = current_adc_grounded ? {`MCC_IBUS_W{1'b0}}
                    : (integrator_on ? cur_integ_in : cur_in);

    genvar ph;
    generate
        for (ph = 0; ph < `MCC_NUM_PHASES; ph = ph + 1) begin : g_phase
            assign volt_res_next[ph*`MCC_SAMPLE_W +: `MCC_SAMPLE_W] = cfg_reg[`MCC_SWAP_BIT]
                ? cur_eff[ph*`MCC_SAMPLE_W +: `MCC_SAMPLE_W]
                : volt_eff[ph*`MCC_SAMPLE_W +: `MCC_SAMPLE_W];
            assign cur_res_next[ph*`MCC_SAMPLE_W +: `MCC_SAMPLE_W] = cfg_reg[`MCC_SWAP_BIT]
                ? volt_eff[ph*`MCC_SAMPLE_W +: `MCC_SAMPLE_W]
                : cur_eff[ph*`MCC_SAMPLE_W +: `MCC_SAMPLE_W];
            assign pwr_volt_next[ph*`MCC_SAMPLE_W +: `MCC_SAMPLE_W] =
                mcc_pick_volt(pair_phase[ph], volt_eff);
        end
    endgenerate

    // neutral current has no voltage partner and is never exchanged
    assign cur_res_next[`MCC_NEUTRAL_IDX*`MCC_SAMPLE_W +: `MCC_SAMPLE_W] =
        cur_eff[`MCC_NEUTRAL_IDX*`MCC_SAMPLE_W +: `MCC_SAMPLE_W];

    always @(posedge aclk) begin
        if (!aresetn) begin
            volt_res <= {`MCC_VBUS_W{1'b0}};
            cur_res  <= {`MCC_IBUS_W{1'b0}};
            pwr_volt <= {`MCC_VBUS_W{1'b0}};
        end else begin
            volt_res <= volt_res_next;
            cur_res  <= cur_res_next;
            pwr_volt <= pwr_volt_next;
        end
    end

    // shared pin: fast port clock or third pulse output
    always @(posedge aclk) begin
        if (!aresetn) begin
            shared_pin_out <= 1'b0;
        end else if (fast_data_port_on) begin
            shared_pin_out <= fast_port_clock_in;
        end else begin
            shared_pin_out <= third_pulse_in;
        end
    end

endmodule // mcc_channel_config
`default_nettype wire

// File: mcc_map.vh
// register map, field positions and counts of the metering channel configuration block
`ifndef MCC_MAP_VH
`define MCC_MAP_VH

`define MCC_ADDR_W        8
`define MCC_DATA_W        32
`define MCC_CFG_W         16
`define MCC_CFG_OFS       8'h00
`define MCC_STAT_OFS      8'h04
`define MCC_WORD_LSB      2

`define MCC_INTEG_BIT     0
`define MCC_SWAP_BIT      3
`define MCC_VGND_BIT      4
`define MCC_IGND_BIT      5
`define MCC_FDP_BIT       6
`define MCC_SOFT_RESET_TRIGGER_BIT     7
`define MCC_SELA_LSB      8
`define MCC_SELB_LSB      10
`define MCC_SELC_LSB      12
`define MCC_SEL_W         2

`define MCC_CFG_MASK      16'h3F79
`define MCC_CFG_RESET     16'h0000
`define MCC_SEL_RSVD      2'h3
`define MCC_SEL_DEFAULT   2'h0

`define MCC_PHASE_A       2'h0
`define MCC_PHASE_B       2'h1
`define MCC_PHASE_C       2'h2
`define MCC_NUM_PHASES    3'h3

`define MCC_STAT_BUSY_BIT 0
`define MCC_STAT_PA_LSB   2
`define MCC_STAT_PB_LSB   4
`define MCC_STAT_PC_LSB   6
`define MCC_STAT_W        8

`define MCC_SAMPLE_W      24
`define MCC_VBUS_W        72
`define MCC_IBUS_W        96
`define MCC_NEUTRAL_IDX   3

`define MCC_SOFT_RESET_TRIGGER_CYCLES  5'h10
`define MCC_CNT_W         5

`define MCC_RESP_OKAY     2'h0
`define MCC_RESP_SLVERR   2'h2

`endif

// File: mcc_channel_config_asserts.sv
// port-level assertions for the channel configuration block
`timescale 1ns/1ps
`default_nettype none
module mcc_channel_config_asserts (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic [95:0] cur_in,
    input wire logic [95:0] cur_integ_in,
    input wire logic        fast_port_clock_in,
    input wire logic        third_pulse_in,
    input wire logic [95:0] cur_res,
    input wire logic [71:0] pwr_volt,
    input wire logic        integrator_on,
    input wire logic        voltage_adc_grounded,
    input wire logic        current_adc_grounded,
    input wire logic        fast_data_port_on,
    input wire logic        shared_pin_out,
    input wire logic        soft_reset_out
);
    // holds checks off at the release edge, while outputs still carry reset values
    logic rst_seen = 1'b0;
    always @(posedge aclk) rst_seen <= aresetn;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn || !rst_seen || soft_reset_out);
    sequence s_busy8;
        soft_reset_out [*8];
    endsequence
    property p_integ;
        integrator_on && !current_adc_grounded |=> cur_res[95:72] == $past(cur_integ_in[95:72]);
    endproperty
    a_integ: assert property (p_integ) else $error("neutral not integrated");
    property p_nointeg;
        !integrator_on && !current_adc_grounded |=> cur_res[95:72] == $past(cur_in[95:72]);
    endproperty
    a_nointeg: assert property (p_nointeg) else $error("neutral not bypassed");
    property p_vgnd;
        voltage_adc_grounded |=> pwr_volt == 72'h0;
    endproperty
    a_vgnd: assert property (p_vgnd) else $error("voltage not grounded");
    property p_ignd;
        current_adc_grounded |=> cur_res[95:72] == 24'h0;
    endproperty
    a_ignd: assert property (p_ignd) else $error("current not grounded");
    property p_fdp;
        fast_data_port_on |=> shared_pin_out == $past(fast_port_clock_in);
    endproperty
    a_fdp: assert property (p_fdp) else $error("shared pin not port clock");
    property p_pulse;
        !fast_data_port_on |=> shared_pin_out == $past(third_pulse_in);
    endproperty
    a_pulse: assert property (p_pulse) else $error("shared pin not pulse");
    property p_soft_reset_trigger;
        disable iff (!aresetn) $rose(soft_reset_out) |-> s_busy8 ##1 s_busy8 ##1 !soft_reset_out;
    endproperty
    a_soft_reset_trigger: assert property (p_soft_reset_trigger) else $error("soft reset length wrong");
    property p_swcfg;
        disable iff (!aresetn) $rose(soft_reset_out) |->
            !(integrator_on || fast_data_port_on || voltage_adc_grounded || current_adc_grounded);
    endproperty
    a_swcfg: assert property (p_swcfg) else $error("soft reset kept config");
    property p_rstval;
        $rose(aresetn) |-> !(integrator_on || fast_data_port_on || voltage_adc_grounded
            || current_adc_grounded || soft_reset_out || shared_pin_out);
    endproperty
    a_rstval: assert property (p_rstval) else $error("reset values wrong");
endmodule // mcc_channel_config_asserts

bind mcc_channel_config mcc_channel_config_asserts u_asserts (.aclk, .aresetn, .cur_in,
    .cur_integ_in, .fast_port_clock_in, .third_pulse_in, .cur_res, .pwr_volt, .integrator_on,
    .voltage_adc_grounded, .current_adc_grounded, .fast_data_port_on, .shared_pin_out,
    .soft_reset_out);
`default_nettype wire

// File: tb_meter_channel_config_reg.sv
// self-checking bench for the channel configuration block
`timescale 1ns/1ps
`default_nettype none
`include "mcc_map.vh"
module tb_meter_channel_config_reg;
    localparam logic [71:0] VIN = 72'hC00003_B00002_A00001;
    localparam logic [95:0] IIN = 96'hD00004_300003_200002_100001;
    localparam logic [95:0] JIN = 96'hE00008_700007_600006_500005;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        fast_port_clock_in = 1'b0, third_pulse_in = 1'b1;
    logic [71:0] volt_in = VIN;
    logic [95:0] cur_in = IIN, cur_integ_in = JIN;
    wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic   integrator_on, voltage_adc_grounded, current_adc_grounded;
    wire logic   fast_data_port_on, shared_pin_out, soft_reset_out;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    wire logic [71:0] volt_res, pwr_volt;
    wire logic [95:0] cur_res;
    int          fail_count = 0, tests_run = 0;

    mcc_channel_config u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .volt_in, .cur_in, .cur_integ_in,
        .fast_port_clock_in, .third_pulse_in, .volt_res, .cur_res, .pwr_volt, .integrator_on,
        .voltage_adc_grounded, .current_adc_grounded, .fast_data_port_on, .shared_pin_out,
        .soft_reset_out);

    always #4 aclk = ~aclk;
    always @(posedge aclk) begin
        fast_port_clock_in <= ~fast_port_clock_in;
        third_pulse_in <= fast_port_clock_in;
    end

    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        check(s_axi_rdata, e);
        check(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask

    task automatic wr_cfg(input logic [15:0] v);
        logic [1:0] r;
        wr(`MCC_CFG_OFS, {16'h0000, v}, 4'h3, r);
        check(r, `MCC_RESP_OKAY);
        repeat (2) @(posedge aclk);
    endtask

    task automatic t_reset;
        rd_chk(`MCC_CFG_OFS, 32'h0, `MCC_RESP_OKAY);
        check({integrator_on, voltage_adc_grounded, current_adc_grounded}, 3'h0);
        check({fast_data_port_on, soft_reset_out}, 2'h0);
        check(pwr_volt, VIN);
        check(cur_res, IIN);
        check(volt_res, VIN);
        $display("test reset done");
    endtask

    task automatic t_fields;
        wr_cfg(16'hFF7F);
        rd_chk(`MCC_CFG_OFS, 32'h3F79, `MCC_RESP_OKAY);
        check({integrator_on, voltage_adc_grounded, current_adc_grounded}, 3'h7);
        check(fast_data_port_on, 1'b1);
        check(pwr_volt, 72'h0);
        check(volt_res, 72'h0);
        check(cur_res, 96'h0);
        check({shared_pin_out}, {~fast_port_clock_in});
        wr_cfg(16'hC006);
        rd_chk(`MCC_CFG_OFS, 32'h0, `MCC_RESP_OKAY);
        check(volt_res, VIN);
        check(cur_res, IIN);
        check(fast_data_port_on, 1'b0);
        check({shared_pin_out}, {fast_port_clock_in});
        $display("test fields done");
    endtask

    task automatic t_select;
        logic [71:0] e;
        logic [1:0]  eff;
        for (int c = 0; c < 4; c++) begin
            eff = (c == 3) ? 2'h0 : c[1:0];
            for (int i = 0; i < 3; i++)
                e[i*24 +: 24] = VIN[((i + eff) % 3)*24 +: 24];
            wr_cfg({2'h0, c[1:0], c[1:0], c[1:0], 8'h00});
            check(pwr_volt, e);
        end
        wr_cfg(16'h0900);
        check(pwr_volt, {VIN[71:48], VIN[23:0], VIN[47:24]});
        rd_chk(`MCC_STAT_OFS, 32'h84, `MCC_RESP_OKAY);
        $display("test select done");
    endtask

    task automatic t_swap;
        wr_cfg(16'h0008);
        check(volt_res, IIN[71:0]);
        check(cur_res, {IIN[95:72], VIN});
        wr_cfg(16'h0001);
        check(cur_res, JIN);
        check(volt_res, VIN);
        $display("test swap done");
    endtask

    task automatic t_soft_reset_trigger;
        wr_cfg(16'h0041);
        wr_cfg(16'h3FF9);
        check(soft_reset_out, 1'b1);
        check({integrator_on, fast_data_port_on}, 2'h0);
        rd_chk(`MCC_CFG_OFS, 32'h0, `MCC_RESP_OKAY);
        rd_chk(`MCC_STAT_OFS, 32'h91, `MCC_RESP_OKAY);
        repeat (20) @(posedge aclk);
        check(soft_reset_out, 1'b0);
        $display("test soft reset done");
    endtask

    task automatic t_bus;
        logic [1:0] r;
        wr(8'h10, 32'hFFFF, 4'hF, r);
        check(r, `MCC_RESP_SLVERR);
        rd_chk(8'h10, 32'h0, `MCC_RESP_SLVERR);
        wr(`MCC_STAT_OFS, 32'hFF, 4'hF, r);
        check(r, `MCC_RESP_OKAY);
        rd_chk(`MCC_STAT_OFS, 32'h90, `MCC_RESP_OKAY);
        wr(`MCC_CFG_OFS, 32'h0101, 4'h2, r);
        check(r, `MCC_RESP_OKAY);
        rd_chk(`MCC_CFG_OFS, 32'h0100, `MCC_RESP_OKAY);
        $display("test bus done");
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #20000;
        fail_count++;
        summarize();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_fields();
        t_select();
        t_swap();
        t_soft_reset_trigger();
        t_bus();
        summarize();
    end
endmodule // tb_meter_channel_config_reg
`default_nettype wire
